// file: rtl/rcr_flow_guard.sv
// Purpose: flags flow changes that land inside the protected segment
// Assumes: pc_load is a one-cycle pulse with kind and target
// Notes: empty window when low bound exceeds high bound
`timescale 1ns/10ps
`default_nettype none
module rcr_flow_guard
  import rcr_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               pc_load,
  input  wire rcr_pkg::rcr_flow_t kind,
  input  wire logic [RCR_PCW-1:0] target,
  input  wire logic               prot_en,
  input  wire logic [RCR_PCW-1:0] prot_lo,
  input  wire logic [RCR_PCW-1:0] prot_hi,
  output logic                    viol,
  output logic                    viol_vector
);
  logic viol_reg;
  logic viol_next;
  logic vec_reg;
  logic vec_next;

  function automatic logic is_vector(input rcr_flow_t k);
    // vector loads vs. every other program counter reload
    case (k)
      RCR_FLOW_IVEC, RCR_FLOW_TVEC: is_vector = 1'b1;   // [RULE_05]
      default:                      is_vector = 1'b0;   // [RULE_04]
    endcase
  endfunction

  always_comb begin
    viol_next = pc_load & prot_en & (target >= prot_lo) & (target <= prot_hi); // [RULE_03]
    vec_next  = vec_reg;
    if (viol_next) begin
      vec_next = is_vector(kind);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      viol_reg <= 1'b0;
      vec_reg  <= 1'b0;
    end else begin
      viol_reg <= viol_next;
      vec_reg  <= vec_next;
    end
  end

  assign viol        = viol_reg;
  assign viol_vector = vec_reg;

  property p_sec_hit;
    @(posedge clk) disable iff (reset)
      pc_load && prot_en && target >= prot_lo && target <= prot_hi |=> viol;
  endproperty
  a_sec_hit: assert property (p_sec_hit) else $error("protected target not flagged"); // [RULE_03]

  property p_sec_kind;
    @(posedge clk) disable iff (reset)
      viol_next && (kind == RCR_FLOW_IVEC || kind == RCR_FLOW_TVEC) |=> viol_vector;
  endproperty
  a_sec_kind: assert property (p_sec_kind) else $error("vector change misclassified"); // [RULE_05]
endmodule
`default_nettype wire

// file: rtl/rcr_pkg.sv
// Purpose: shared constants and types for the reset cause recorder
// Assumes: byte addressed classic Wishbone, 32-bit data
// Notes: flag positions follow the cause register layout
package rcr_pkg;
  localparam int          RCR_AW          = 5;
  localparam int          RCR_DW          = 32;
  localparam int          RCR_FW          = 16;
  localparam int          RCR_PCW         = 24;
  localparam int          RCR_NWREG       = 16;
  localparam int          RCR_WIW         = 4;
  localparam logic [4:0]  RCR_OFS_CAUSE   = 5'h00;
  localparam logic [4:0]  RCR_OFS_PROT_LO = 5'h04;
  localparam logic [4:0]  RCR_OFS_PROT_HI = 5'h08;
  localparam logic [4:0]  RCR_OFS_WREG    = 5'h0C;
  localparam logic [4:0]  RCR_OFS_CTRL    = 5'h10;
  localparam int          RCR_B_TRAP      = 15;
  localparam int          RCR_B_ILL       = 14;
  localparam int          RCR_B_CM        = 9;
  localparam int          RCR_B_EXTERNAL_PIN_RESET_FLAG      = 7;
  localparam int          RCR_B_SWR       = 6;
  localparam int          RCR_B_WATCHDOG_TIMEOUT_FLAG      = 4;
  localparam int          RCR_B_SLEEP     = 3;
  localparam int          RCR_B_IDLE      = 2;
  localparam int          RCR_B_BOR       = 1;
  localparam int          RCR_B_POR       = 0;
  localparam logic [15:0] RCR_FLAG_MASK   = 16'hC2DF;
  localparam logic [15:0] RCR_CAUSE_RST   = 16'h0003;
  localparam logic [15:0] RCR_WREG_RST    = 16'h8000;
  localparam logic [3:0]  RCR_TOP_WREG    = 4'hF;
  localparam logic [3:0]  RCR_HTRAP_LO    = 4'hD;
  localparam logic [3:0]  RCR_HTRAP_HI    = 4'hF;
  localparam logic [23:0] RCR_RESET_PC    = 24'h000000;
  localparam logic [23:0] RCR_PROT_LO_RST = 24'hFFFFFF;
  localparam logic [23:0] RCR_PROT_HI_RST = 24'h000000;
  localparam logic        RCR_CTRL_RST    = 1'b0;

  typedef enum logic [2:0] {
    RCR_FLOW_CALL, RCR_FLOW_JUMP, RCR_FLOW_CJUMP, RCR_FLOW_RET,
    RCR_FLOW_RETSUB, RCR_FLOW_BRANCH, RCR_FLOW_IVEC, RCR_FLOW_TVEC
  } rcr_flow_t;

  typedef enum {RCR_RUN, RCR_HOLD, RCR_RESTART} rcr_state_t;
endpackage

// file: rtl/rcr_top.sv
// Purpose: records reset causes and sequences the device restart
// Assumes: all event inputs are one-cycle pulses on clk
// Notes: module reset acts as power-on; commits on the ack edge
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
// Operation
// RULE_01 - Pointer use of an unwritten working register resets the device.
// RULE_02 - Every reset clears working registers except the top one.
// RULE_03 - Flow change into protected segment raises a security reset.
// RULE_04 - Calls, jumps, returns and branches count as program flow changes.
// RULE_05 - Interrupt or trap vector loads count as vector flow changes.
// RULE_06 - Software should clear cause flags after reading them.
// RULE_07 - Trap conflict flag bit 15: set by conflict, cleared by POR/BOR.
// RULE_08 - Illegal flag bit 14: opcode, uninit register, security; POR/BOR clear.
// RULE_09 - Config mismatch flag bit 9: set by mismatch, POR/BOR clear.
// RULE_10 - Pin reset flag bit 7: set by master clear, POR only clears.
// RULE_11 - Software reset flag bit 6: reset instruction, POR/BOR clear.
// RULE_12 - Watchdog flag bit 4: timeout sets; power-save, clear, POR, BOR clear.
// RULE_13 - Sleep flag bit 3: set on sleep entry, POR/BOR clear.
// RULE_14 - Idle flag bit 2: set on idle entry, POR/BOR clear.
// RULE_15 - Brown-out bit 1 by POR/BOR, power-on bit 0 by POR.
// RULE_16 - Software can set and clear every cause flag.
// RULE_17 - Any reset restarts execution at program address zero.
// RULE_18 - Hard trap 13-15 under a higher trap is a conflict.
// RULE_19 - Executing an illegal opcode resets the device.
// RULE_20 - Flags stay set until their clear event or a write.
module rcr_top
  import rcr_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [rcr_pkg::RCR_AW-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [rcr_pkg::RCR_DW-1:0] wb_dat_i,
  output logic      [rcr_pkg::RCR_DW-1:0] wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic                       por_i,
  input  wire logic                       bor_i,
  input  wire logic                       master_clear_pin_i,
  input  wire logic                       swr_i,
  input  wire logic                       wdt_timeout_i,
  input  wire logic                       watchdog_clear_instruction_i,
  input  wire logic                       power_save_instruction_sleep_i,
  input  wire logic                       power_save_instruction_idle_i,
  input  wire logic                       cfg_mismatch_i,
  input  wire logic                       illegal_opcode_i,
  input  wire logic                       trap_req_i,
  input  wire logic [3:0]                 trap_level_i,
  input  wire logic                       trap_busy_i,
  input  wire logic [3:0]                 trap_busy_level_i,
  input  wire logic                       wr_en_i,
  input  wire logic [rcr_pkg::RCR_WIW-1:0] wr_idx_i,
  input  wire logic                       ptr_use_i,
  input  wire logic [rcr_pkg::RCR_WIW-1:0] ptr_idx_i,
  input  wire logic                       pc_load_i,
  input  wire rcr_pkg::rcr_flow_t         flow_kind_i,
  input  wire logic [rcr_pkg::RCR_PCW-1:0] pc_target_i,
  output logic                            dev_reset_o,
  output logic                            restart_o,
  output logic      [rcr_pkg::RCR_PCW-1:0] restart_pc_o,
  output logic                            wake_o,
  output logic                            low_power_o
);
  import rcr_pkg::*;

  function automatic logic [23:0] lane_merge(input logic [23:0] old,
                                             input logic [31:0] dat,
                                             input logic [3:0]  sel);
    // byte-lane update of a narrow register
    lane_merge = old;
    for (int i = 0; i < 3; i++) begin
      if (sel[i]) begin
        lane_merge[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
  endfunction

  rcr_state_t           state_reg;
  rcr_state_t           state_next;
  logic [RCR_FW-1:0]    cause_reg;
  logic [RCR_FW-1:0]    cause_next;
  logic [RCR_PCW-1:0]   prot_lo_reg;
  logic [RCR_PCW-1:0]   prot_lo_next;
  logic [RCR_PCW-1:0]   prot_hi_reg;
  logic [RCR_PCW-1:0]   prot_hi_next;
  logic                 prot_en_reg;
  logic                 prot_en_next;
  logic                 lp_reg;
  logic                 lp_next;
  logic                 wake_reg;
  logic                 wake_next;
  logic [RCR_PCW-1:0]   rpc_reg;
  logic [RCR_PCW-1:0]   rpc_next;
  logic                 ack_reg;
  logic                 ack_next;
  logic [RCR_DW-1:0]    dat_reg;
  logic [RCR_DW-1:0]    dat_next;
  logic                 bus_req;
  logic                 bus_wr;
  logic                 wr_cause;
  logic                 trap_conflict;
  logic                 uninit_fault;
  logic                 sec_fault;
  logic                 ill_event;
  logic                 wdt_reset;
  logic                 any_cause;
  logic [RCR_NWREG-1:0] wreg_mask;

  rcr_wreg_track u_wreg (
    .clk       (clk),
    .reset     (reset),
    .clear     (dev_reset_o),
    .wr_en     (wr_en_i),
    .wr_idx    (wr_idx_i),
    .use_en    (ptr_use_i),
    .use_idx   (ptr_idx_i),
    .fault     (uninit_fault),
    .init_mask (wreg_mask)
  );

  rcr_flow_guard u_guard (
    .clk         (clk),
    .reset       (reset),
    .pc_load     (pc_load_i),
    .kind        (flow_kind_i),
    .target      (pc_target_i),
    .prot_en     (prot_en_reg),
    .prot_lo     (prot_lo_reg),
    .prot_hi     (prot_hi_reg),
    .viol        (sec_fault),
    .viol_vector ()
  );

  // bus: ack one cycle after request, write lands on the ack edge
  assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign bus_wr   = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i;
  assign wr_cause = bus_wr & (wb_adr_i == RCR_OFS_CAUSE);

  // trap conflict: hard trap below the level being serviced
  assign trap_conflict = trap_req_i & trap_busy_i
                       & (trap_level_i >= RCR_HTRAP_LO)
                       & (trap_level_i <= RCR_HTRAP_HI)
                       & (trap_level_i < trap_busy_level_i); // [RULE_18]
  assign ill_event = illegal_opcode_i | uninit_fault | sec_fault; // [RULE_19]
  // watchdog in sleep or idle wakes instead of resetting
  assign wdt_reset = wdt_timeout_i & ~lp_reg;
  assign any_cause = por_i | bor_i | master_clear_pin_i | swr_i | wdt_reset
                   | cfg_mismatch_i | ill_event | trap_conflict; // [RULE_01] [RULE_03]

  always_comb begin
    ack_next = bus_req;
    dat_next = dat_reg;
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        RCR_OFS_CAUSE:   dat_next = {16'h0000, cause_reg};
        RCR_OFS_PROT_LO: dat_next = {8'h00, prot_lo_reg};
        RCR_OFS_PROT_HI: dat_next = {8'h00, prot_hi_reg};
        RCR_OFS_WREG:    dat_next = {16'h0000, wreg_mask};
        RCR_OFS_CTRL:    dat_next = {30'h00000000, lp_reg, prot_en_reg};
        default:         dat_next = 32'h00000000;
      endcase
    end
  end

  always_comb begin
    prot_lo_next = prot_lo_reg;
    prot_hi_next = prot_hi_reg;
    prot_en_next = prot_en_reg;
    if (bus_wr && wb_adr_i == RCR_OFS_PROT_LO) begin
      prot_lo_next = lane_merge(prot_lo_reg, wb_dat_i, wb_sel_i);
    end
    if (bus_wr && wb_adr_i == RCR_OFS_PROT_HI) begin
      prot_hi_next = lane_merge(prot_hi_reg, wb_dat_i, wb_sel_i);
    end
    if (bus_wr && wb_adr_i == RCR_OFS_CTRL && wb_sel_i[0]) begin
      prot_en_next = wb_dat_i[0];
    end
  end

  // cause flags: write, then hardware clears, then hardware sets
  always_comb begin
    cause_next = cause_reg;                               // [RULE_20]
    if (wr_cause) begin
      if (wb_sel_i[0]) begin
        cause_next[7:0] = wb_dat_i[7:0];                  // [RULE_16]
      end
      if (wb_sel_i[1]) begin
        cause_next[15:8] = wb_dat_i[15:8];                // [RULE_16]
      end
    end
    if (por_i) begin
      cause_next = 16'h0000;                              // [RULE_10]
    end else if (bor_i) begin
      cause_next = cause_next & (16'h0001 << RCR_B_EXTERNAL_PIN_RESET_FLAG); // [RULE_10]
    end
    if (power_save_instruction_sleep_i || power_save_instruction_idle_i || watchdog_clear_instruction_i) begin
      cause_next[RCR_B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;                      // [RULE_12]
    end
    if (trap_conflict) begin
      cause_next[RCR_B_TRAP] = 1'b1;                      // [RULE_07]
    end
    if (ill_event) begin
      cause_next[RCR_B_ILL] = 1'b1;                       // [RULE_08]
    end
    if (cfg_mismatch_i) begin
      cause_next[RCR_B_CM] = 1'b1;                        // [RULE_09]
    end
    if (master_clear_pin_i) begin
      cause_next[RCR_B_EXTERNAL_PIN_RESET_FLAG] = 1'b1;                      // [RULE_10]
    end
    if (swr_i) begin
      cause_next[RCR_B_SWR] = 1'b1;                       // [RULE_11]
    end
    if (wdt_timeout_i) begin
      cause_next[RCR_B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;                      // [RULE_12]
    end
    if (power_save_instruction_sleep_i) begin
      cause_next[RCR_B_SLEEP] = 1'b1;                     // [RULE_13]
    end
    if (power_save_instruction_idle_i) begin
      cause_next[RCR_B_IDLE] = 1'b1;                      // [RULE_14]
    end
    if (por_i || bor_i) begin
      cause_next[RCR_B_BOR] = 1'b1;                       // [RULE_15]
    end
    if (por_i) begin
      cause_next[RCR_B_POR] = 1'b1;                       // [RULE_15]
    end
    cause_next = cause_next & RCR_FLAG_MASK;
  end

  // restart sequencer and low-power state
  always_comb begin
    state_next = state_reg;
    rpc_next   = rpc_reg;
    lp_next    = lp_reg;
    wake_next  = 1'b0;
    if (power_save_instruction_sleep_i || power_save_instruction_idle_i) begin
      lp_next = 1'b1;
    end
    if (wdt_timeout_i && lp_reg) begin
      lp_next   = 1'b0;
      wake_next = 1'b1;
    end
    case (state_reg)
      RCR_RUN: begin
        if (any_cause) begin
          state_next = RCR_HOLD;
        end
      end
      RCR_HOLD: begin
        state_next = RCR_RESTART;
        rpc_next   = RCR_RESET_PC;                        // [RULE_17]
        lp_next    = 1'b0;
      end
      RCR_RESTART: begin
        state_next = any_cause ? RCR_HOLD : RCR_RUN;
      end
      default: begin
        state_next = RCR_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg   <= RCR_RUN;
      cause_reg   <= RCR_CAUSE_RST;
      prot_lo_reg <= RCR_PROT_LO_RST;
      prot_hi_reg <= RCR_PROT_HI_RST;
      prot_en_reg <= RCR_CTRL_RST;
      lp_reg      <= 1'b0;
      wake_reg    <= 1'b0;
      rpc_reg     <= RCR_RESET_PC;
      ack_reg     <= 1'b0;
      dat_reg     <= 32'h00000000;
    end else begin
      state_reg   <= state_next;
      cause_reg   <= cause_next;
      prot_lo_reg <= prot_lo_next;
      prot_hi_reg <= prot_hi_next;
      prot_en_reg <= prot_en_next;
      lp_reg      <= lp_next;
      wake_reg    <= wake_next;
      rpc_reg     <= rpc_next;
      ack_reg     <= ack_next;
      dat_reg     <= dat_next;
    end
  end

  assign wb_ack_o     = ack_reg;
  assign wb_dat_o     = dat_reg;
  assign dev_reset_o  = (state_reg == RCR_HOLD);
  assign restart_o    = (state_reg == RCR_RESTART);
  assign restart_pc_o = rpc_reg;
  assign wake_o       = wake_reg;
  assign low_power_o  = lp_reg;

  property p_trap;
    @(posedge clk) disable iff (reset)
      trap_conflict && !por_i && !bor_i |=> cause_reg[RCR_B_TRAP];
  endproperty
  a_trap: assert property (p_trap) else $error("trap conflict flag missed"); // [RULE_07]

  property p_uninit;
    @(posedge clk) disable iff (reset)
      ptr_use_i && !wreg_mask[ptr_idx_i] ##1 !por_i && !bor_i |=> cause_reg[RCR_B_ILL];
  endproperty
  a_uninit: assert property (p_uninit) else $error("uninit use not flagged"); // [RULE_08]

  property p_bor_keeps_pin;
    @(posedge clk) disable iff (reset)
      bor_i && !por_i && !master_clear_pin_i && !wr_cause |=> cause_reg[RCR_B_EXTERNAL_PIN_RESET_FLAG] == $past(cause_reg[RCR_B_EXTERNAL_PIN_RESET_FLAG]);
  endproperty
  a_bor_keeps_pin: assert property (p_bor_keeps_pin) else $error("brown-out touched pin flag"); // [RULE_10]

  property p_por;
    @(posedge clk) disable iff (reset)
      por_i && !master_clear_pin_i |=> cause_reg[1:0] == 2'b11 && !cause_reg[RCR_B_EXTERNAL_PIN_RESET_FLAG];
  endproperty
  a_por: assert property (p_por) else $error("power-on flags wrong"); // [RULE_15]

  property p_watchdog_timeout_flag_clr;
    @(posedge clk) disable iff (reset)
      watchdog_clear_instruction_i && !wdt_timeout_i |=> !cause_reg[RCR_B_WATCHDOG_TIMEOUT_FLAG];
  endproperty
  a_watchdog_timeout_flag_clr: assert property (p_watchdog_timeout_flag_clr) else $error("watchdog flag not cleared"); // [RULE_12]

  property p_sticky;
    @(posedge clk) disable iff (reset)
      !reset && !wr_cause && !any_cause && !wdt_timeout_i && !watchdog_clear_instruction_i
      && !power_save_instruction_sleep_i && !power_save_instruction_idle_i |=> $stable(cause_reg);
  endproperty
  a_sticky: assert property (p_sticky) else $error("cause flags drifted"); // [RULE_20]

  property p_restart;
    @(posedge clk) disable iff (reset)
      state_reg == RCR_RUN && any_cause |=> dev_reset_o ##1 restart_o && restart_pc_o == 24'h000000
      && wreg_mask == 16'h8000;
  endproperty
  a_restart: assert property (p_restart) else $error("restart sequence broken"); // [RULE_17] [RULE_02]

  property p_sw_write;
    @(posedge clk) disable iff (reset)
      wr_cause && wb_sel_i[1:0] == 2'b11 && !any_cause && !wdt_timeout_i && !watchdog_clear_instruction_i
      && !power_save_instruction_sleep_i && !power_save_instruction_idle_i |=> cause_reg == ($past(wb_dat_i[15:0]) & 16'hC2DF);
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("software write lost"); // [RULE_16]

  property p_ack;
    @(posedge clk) disable iff (reset)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack timing wrong");
endmodule
`default_nettype wire

// file: rtl/rcr_wreg_track.sv
// Purpose: remembers which working registers were written since reset
// Assumes: write and pointer use are one-cycle pulses
// Notes: a use in the cycle of a write sees the state before it
`timescale 1ns/10ps
`default_nettype none
module rcr_wreg_track
  import rcr_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                clear,
  input  wire logic                wr_en,
  input  wire logic [RCR_WIW-1:0]  wr_idx,
  input  wire logic                use_en,
  input  wire logic [RCR_WIW-1:0]  use_idx,
  output logic                     fault,
  output logic [RCR_NWREG-1:0]     init_mask
);
  logic [RCR_NWREG-1:0] mask_reg;
  logic [RCR_NWREG-1:0] mask_next;
  logic                 fault_reg;
  logic                 fault_next;

  always_comb begin
    mask_next  = mask_reg;
    fault_next = use_en & ~mask_reg[use_idx];           // [RULE_01]
    if (clear) begin
      mask_next = RCR_WREG_RST;                          // [RULE_02]
    end else if (wr_en) begin
      mask_next[wr_idx] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask_reg  <= RCR_WREG_RST;
      fault_reg <= 1'b0;
    end else begin
      mask_reg  <= mask_next;
      fault_reg <= fault_next;
    end
  end

  assign fault     = fault_reg;
  assign init_mask = mask_reg;
endmodule
`default_nettype wire

// file: verif/rcr_core_model.sv
// Purpose: core and reset source model around the recorder
// Assumes: every action is a one-clock pulse launched after an edge
// Notes: idle qualifiers are scrambled so stale values never match
`timescale 1ns/10ps
`default_nettype none
module rcr_core_model
  import rcr_pkg::*;
(
  input  wire logic              clk,
  output logic [9:0]             ev,
  output logic                   trap_req,
  output logic [3:0]             trap_lvl,
  output logic                   trap_busy,
  output logic [3:0]             busy_lvl,
  output logic                   wr_en,
  output logic [3:0]             wr_idx,
  output logic                   ptr_use,
  output logic [3:0]             ptr_idx,
  output logic                   pc_load,
  output var rcr_pkg::rcr_flow_t kind,
  output logic [23:0]            target
);
  initial begin
    {ev, trap_req, trap_busy, wr_en, ptr_use, pc_load} = '0;
    {trap_lvl, busy_lvl, wr_idx, ptr_idx, target} = '0;
    kind = RCR_FLOW_CALL;
  end

  // op: 0 source event, 1 trap, 2 write, 3 pointer use, 4 flow change
  task act(input int op, input int a, input int b);
    @(posedge clk);
    case (op)
      0: ev[a] <= 1'b1;
      1: {trap_req, trap_busy, trap_lvl, busy_lvl} <= {2'b11, a[3:0], b[3:0]};
      2: {wr_en, wr_idx} <= {1'b1, a[3:0]};
      3: {ptr_use, ptr_idx} <= {1'b1, a[3:0]};
      default: begin
        pc_load <= 1'b1;
        kind <= rcr_flow_t'(a[2:0]);
        target <= b[23:0];
      end
    endcase
    @(posedge clk);
    {ev, trap_req, trap_busy, wr_en, ptr_use, pc_load} <= '0;
    {trap_lvl, busy_lvl, wr_idx, ptr_idx} <= ~{trap_lvl, busy_lvl, wr_idx, ptr_idx};
    target <= ~target;
  endtask
endmodule
`default_nettype wire

// file: verif/tb_rcr_top.sv
// Purpose: self-checking bench for the reset cause recorder
// Assumes: bus answers one cycle after each request
// Notes: rows clear the cause flags, fire one action, read back
`timescale 1ns/10ps
`default_nettype none
module tb_rcr_top;
  import rcr_pkg::*;
  typedef struct {int op; int a; int b; logic [15:0] exp; int nrst;} rcr_row_t;
  logic        clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [4:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, trap_lvl, busy_lvl, wr_idx, ptr_idx;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [9:0]  ev;
  logic        trap_req, trap_busy, wr_en, ptr_use, pc_load;
  logic        dev_reset_o, restart_o, wake_o, low_power_o;
  logic [23:0] target, restart_pc_o;
  rcr_flow_t   kind;
  int          err_count = 0, check_count = 0, rcount = 0, scount = 0, wcount = 0, w0;
  rcr_row_t    rows [0:22] = '{
    '{0,0,0,16'h0003,1}, '{0,1,0,16'h0002,1}, '{0,2,0,16'h0080,1}, '{0,3,0,16'h0040,1},
    '{0,4,0,16'h0010,1}, '{0,5,0,16'h0000,0}, '{0,8,0,16'h0200,1}, '{0,9,0,16'h4000,1},
    '{0,6,0,16'h0008,0}, '{0,7,0,16'h0004,0}, '{1,13,14,16'h8000,1}, '{1,14,15,16'h8000,1},
    '{1,12,14,16'h0000,0}, '{1,15,14,16'h0000,0}, '{1,13,13,16'h0000,0},
    '{2,3,0,16'h0000,0}, '{3,3,0,16'h0000,0}, '{3,15,0,16'h0000,0}, '{3,5,0,16'h4000,1},
    '{3,3,0,16'h4000,1}, '{4,0,'h1FF,16'h4000,1}, '{4,0,'h200,16'h0000,0},
    '{4,0,'hFF,16'h0000,0}};

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (dev_reset_o === 1'b1) rcount <= rcount + 1;
    if (restart_o === 1'b1 && restart_pc_o === 24'h000000) scount <= scount + 1;
    if (wake_o === 1'b1) wcount <= wcount + 1;
  end

  rcr_core_model i_core (.clk, .ev, .trap_req, .trap_lvl, .trap_busy, .busy_lvl, .wr_en,
    .wr_idx, .ptr_use, .ptr_idx, .pc_load, .kind, .target);

  rcr_top i_dut (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .por_i(ev[0]), .bor_i(ev[1]), .master_clear_pin_i(ev[2]),
    .swr_i(ev[3]), .wdt_timeout_i(ev[4]), .watchdog_clear_instruction_i(ev[5]), .power_save_instruction_sleep_i(ev[6]),
    .power_save_instruction_idle_i(ev[7]), .cfg_mismatch_i(ev[8]), .illegal_opcode_i(ev[9]),
    .trap_req_i(trap_req), .trap_level_i(trap_lvl), .trap_busy_i(trap_busy),
    .trap_busy_level_i(busy_lvl), .wr_en_i(wr_en), .wr_idx_i(wr_idx), .ptr_use_i(ptr_use),
    .ptr_idx_i(ptr_idx), .pc_load_i(pc_load), .flow_kind_i(kind), .pc_target_i(target),
    .dev_reset_o, .restart_o, .restart_pc_o, .wake_o, .low_power_o);

  task automatic wrap_up;
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (wb_ack_o !== 1'b1) begin
      err_count++;
      wrap_up();
    end
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask

  task automatic rd(input logic [4:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk(q, exp);
  endtask

  task automatic evrd(input int op, input int a, input int b, input logic [15:0] exp);
    i_core.act(op, a, b);
    repeat (4) @(posedge clk);
    rd(RCR_OFS_CAUSE, {16'h0, exp});
  endtask

  task automatic run(input rcr_row_t r);
    int r0, s0;
    if (r.op == 4) begin
      wb(1'b1, RCR_OFS_PROT_LO, 32'h100);
      wb(1'b1, RCR_OFS_PROT_HI, 32'h1FF);
      wb(1'b1, RCR_OFS_CTRL, 32'h1);
    end
    wb(1'b1, RCR_OFS_CAUSE, 32'h0);
    r0 = rcount;
    s0 = scount;
    evrd(r.op, r.a, r.b, r.exp);
    chk(rcount - r0, r.nrst);
    chk(scount - s0, r.nrst);
  endtask

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    reset = 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(RCR_OFS_CAUSE, 32'h3);
    rd(RCR_OFS_WREG, 32'h8000);
    rd(RCR_OFS_PROT_LO, 32'hFFFFFF);
    rd(RCR_OFS_CTRL, 32'h0);
    wb(1'b1, 5'h14, 32'hFFFF);
    rd(5'h14, 32'h0);
    wb(1'b1, RCR_OFS_CAUSE, 32'hFFFF);
    rd(RCR_OFS_CAUSE, 32'hC2DF);
    wb(1'b1, RCR_OFS_CAUSE, 32'h0);
    rd(RCR_OFS_CAUSE, 32'h0);
    wb_sel_i <= 4'h2;
    wb(1'b1, RCR_OFS_CAUSE, 32'hFFFF);
    wb_sel_i <= 4'hF;
    rd(RCR_OFS_CAUSE, 32'hC200);
    for (int i = 0; i < 23; i++) run(rows[i]);
    for (int k = 0; k < 8; k++) run('{4, k, 'h100, 16'h4000, 1});
    wb(1'b1, RCR_OFS_CAUSE, 32'h0);
    evrd(0, 2, 0, 16'h0080);
    evrd(0, 3, 0, 16'h00C0);
    evrd(0, 1, 0, 16'h0082);
    evrd(0, 0, 0, 16'h0003);
    wb(1'b1, RCR_OFS_CAUSE, 32'h0);
    evrd(0, 4, 0, 16'h0010);
    evrd(0, 5, 0, 16'h0000);
    evrd(0, 6, 0, 16'h0008);
    w0 = wcount;
    evrd(0, 4, 0, 16'h0018);
    chk(wcount - w0, 1);
    wb(1'b0, RCR_OFS_CTRL, 32'h0);
    chk(q & 32'h2, 32'h0);
    chk({31'h0, low_power_o}, 32'h0);
    evrd(0, 7, 0, 16'h000C);
    wb(1'b0, RCR_OFS_CTRL, 32'h0);
    chk(q & 32'h2, 32'h2);
    chk({31'h0, low_power_o}, 32'h1);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    rd(RCR_OFS_CAUSE, 32'h3);
    wrap_up();
  end

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
